// >>> rtl/adc_pkg.sv
package adc_pkg;
	// register offsets on the plain register port
	localparam logic [2:0] ADDR_RESULT_HIGH = 3'h0;
	localparam logic [2:0] ADDR_RESULT_LOW = 3'h1;
	localparam logic [2:0] ADDR_CTRL_ZERO = 3'h2;
	localparam logic [2:0] ADDR_PIN_REF = 3'h3;
	localparam logic [2:0] ADDR_TIMING = 3'h4;
	// field positions
	localparam int ENABLE_BIT = 0;
	localparam int GO_BIT = 1;
	localparam int CHANNEL_LSB = 2;
	localparam int PCFG_LSB = 0;
	localparam int POS_REF_BIT = 4;
	localparam int NEG_REF_BIT = 5;
	localparam int CLK_SEL_LSB = 0;
	localparam int ACQ_LSB = 3;
	localparam int JUSTIFY_BIT = 7;
	// reset values
	localparam logic [3:0] CHANNEL_RESET = 4'h0;
	localparam logic [2:0] ACQ_RESET = 3'h0;
	localparam logic [2:0] CLK_SEL_RESET = 3'h0;
	localparam logic [2:0] PCFG_LOW_ANALOG = 3'h0;
	localparam logic [2:0] PCFG_LOW_DIGITAL = 3'h7;
	// converter shape
	localparam int CHANNELS = 13;
	localparam int RESULT_BITS = 10;
	localparam logic [3:0] PCFG_ALL_ANALOG = 4'h2;
	localparam logic [3:0] CONV_PERIODS = 4'hb;
	localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;
	localparam logic [1:0] RC_CODE = 2'h3;
	// one instruction cycle is four oscillator periods
	localparam int CLOCK_PERIOD_NS = 100;
	localparam int INSTR_CYCLE_NS = 400;
	localparam int INSTR_CYCLE_CLOCKS =
		(INSTR_CYCLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_ACQ = 2'h1,
		ST_CONV = 2'h3
	} conv_state_t;

	// system clock divisor per conversion clock code
	function automatic logic [6:0] clock_divisor(input logic [2:0] code);
		case (code)
			3'h0: return 7'h02;
			3'h1: return 7'h08;
			3'h2: return 7'h20;
			3'h4: return 7'h04;
			3'h5: return 7'h10;
			3'h6: return 7'h40;
			default: return 7'h01;
		endcase
	endfunction

	// acquisition length in bit periods per code
	function automatic logic [4:0] acq_periods(input logic [2:0] code);
		case (code)
			3'h1: return 5'h02;
			3'h2: return 5'h04;
			3'h3: return 5'h06;
			3'h4: return 5'h08;
			3'h5: return 5'h0c;
			3'h6: return 5'h10;
			3'h7: return 5'h14;
			default: return 5'h00;
		endcase
	endfunction
endpackage

// >>> rtl/bit_period_gen.sv
`timescale 1ns/1ps
module bit_period_gen #(
	parameter int DELAY_CLOCKS = adc_pkg::INSTR_CYCLE_CLOCKS
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic run,
	input wire logic [2:0] clock_select,
	input wire logic rc_osc,
	input wire logic sleeping,
	output logic tick
);
	typedef struct packed {
		logic rc_meta;
		logic rc_sync;
		logic rc_last;
		logic [6:0] div_count;
		logic [3:0] delay_count;
		logic tick;
	} gen_state_t;

	gen_state_t s_reg;
	gen_state_t s_next;
	logic rc_sel;

	assign rc_sel = clock_select[1:0] == adc_pkg::RC_CODE;
	assign tick = s_reg.tick;

	// one tick per bit period; counters restart with each run
	always_comb begin
		s_next = s_reg;
		s_next.rc_meta = rc_osc;
		s_next.rc_sync = s_reg.rc_meta;
		s_next.rc_last = s_reg.rc_sync;
		s_next.tick = 1'b0;
		if (!run) begin
			s_next.div_count = 7'h00;
			s_next.delay_count = 4'h0;
		end else if (rc_sel) begin
			// rc clock held off one instruction cycle
			if (s_reg.delay_count != 4'(DELAY_CLOCKS)) begin
				s_next.delay_count = s_reg.delay_count + 4'h1;
			end else if (s_reg.rc_sync && !s_reg.rc_last) begin
				s_next.tick = 1'b1;
			end
		end else if (!sleeping) begin
			// system clock stops in sleep, so its divider freezes
			if (s_reg.div_count ==
				adc_pkg::clock_divisor(clock_select) - 7'h01) begin
				s_next.div_count = 7'h00;
				s_next.tick = 1'b1;
			end else begin
				s_next.div_count = s_reg.div_count + 7'h01;
			end
		end
		if (!resetn) begin
			s_next = '0;
		end
	end

	always_ff @(posedge clock) begin
		s_reg <= s_next;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	sleep_stop_a: assert property (
		run && sleeping && !rc_sel |=> !tick)
		else $error("system clock tick while sleeping");

	rc_delay_a: assert property (
		$rose(run) && rc_sel |-> !tick [*4])
		else $error("rc tick inside start delay");
endmodule

// >>> rtl/adc_conversion_control.sv
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
//Behaviour
// - channel code 0..12 routes that analog input; 13..15 route none.
// - unimplemented channel still converts normally, measuring a floating input.
// - go bit reads 1 while converting and 0 when idle.
// - enable bit turns converter on when set, off when cleared.
// - negative reference bit selects external reference pin or ground.
// - positive reference bit selects external reference pin or supply.
// - pin code 0..2 all analog; each higher code digitalises one more top pin.
// - at reset low pin code bits load 000 or 111 by strap.
// - justify bit set gives right justified result, clear gives left.
// - acquisition code selects 0,2,4,6,8,12,16,20 bit periods.
// - clock code selects system clock divisor or the internal rc clock.
// - rc clock starts one instruction cycle after go, before any acquisition interval.
// - conversion runs in sleep only on the rc clock; software chooses it.
// - result found by successive approximation on the held sample.
// - reset restores control registers, disables and aborts conversion.
// - on completion load results, clear go, raise done flag.
// - reset leaves the result register pair untouched.
// - programmed acquisition interval runs between go and conversion start.
// - a conversion lasts eleven bit periods.
// - acquisition code zero starts conversion immediately on go.
// - after completion sampling of the selected channel resumes.
module adc_conversion_control (
	input wire logic clock,
	input wire logic resetn,
	input wire logic port_b_analog_default,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic write_strobe,
	input wire logic read_strobe,
	output logic [7:0] rdata,
	input wire logic internal_rc_clock,
	input wire logic sleeping,
	input wire logic comp_keep,
	output logic [12:0] channel_onehot,
	output logic [12:0] analog_mask,
	output logic neg_ref_select,
	output logic pos_ref_select,
	output logic sample_enable,
	output logic [9:0] dac_code,
	output logic converter_enable,
	output logic conversion_done_flag
);
	typedef struct packed {
		logic [3:0] channel;
		logic go;
		logic enable;
		logic nref;
		logic pref;
		logic [3:0] pcfg;
		logic justify;
		logic [2:0] acq;
		logic [2:0] clk_sel;
		logic [7:0] result_high;
		logic [7:0] result_low;
		adc_pkg::conv_state_t st;
		logic [4:0] acq_count;
		logic [3:0] conv_ticks;
		logic [9:0] sar;
		logic [9:0] trial;
		logic done;
		logic [7:0] rdata;
		logic comp_sync;
	} ctl_state_t;

	ctl_state_t s_reg;
	ctl_state_t s_next;
	logic tick;
	logic start;
	logic ctrl_write;
	logic [4:0] digital_count;

	// bit period source, idle whenever no conversion is pending
	bit_period_gen #(
		.DELAY_CLOCKS(adc_pkg::INSTR_CYCLE_CLOCKS)
	) u_bit_period (
		.clock(clock),
		.resetn(resetn),
		.run(s_reg.st != adc_pkg::ST_IDLE),
		.clock_select(s_reg.clk_sel),
		.rc_osc(internal_rc_clock),
		.sleeping(sleeping),
		.tick(tick)
	);

	// go is taken only with enable in the same write and when idle
	assign ctrl_write = write_strobe && addr == adc_pkg::ADDR_CTRL_ZERO;
	assign start = ctrl_write && wdata[adc_pkg::GO_BIT] &&
		wdata[adc_pkg::ENABLE_BIT] && s_reg.st == adc_pkg::ST_IDLE;

	// number of top pins turned digital by the pin code
	always_comb begin
		digital_count = 5'h00;
		if (s_reg.pcfg > adc_pkg::PCFG_ALL_ANALOG) begin
			digital_count = {1'b0, s_reg.pcfg} -
				{1'b0, adc_pkg::PCFG_ALL_ANALOG};
		end
	end

	// per-input channel route and analog/digital mode
	for (genvar i = 0; i < adc_pkg::CHANNELS; i++) begin : g_pin
		// codes above 12 match no input, the mux floats
		assign channel_onehot[i] = s_reg.channel == 4'(i);
		assign analog_mask[i] =
			(5'(i) + digital_count) < 5'(adc_pkg::CHANNELS);
	end

	assign neg_ref_select = s_reg.nref;
	assign pos_ref_select = s_reg.pref;
	// hold capacitor tracks the input while enabled and no conversion runs
	assign sample_enable = s_reg.enable &&
		s_reg.st != adc_pkg::ST_CONV;
	assign dac_code = s_reg.sar;
	assign converter_enable = s_reg.enable;
	assign conversion_done_flag = s_reg.done;
	assign rdata = s_reg.rdata;

	// register port, sequencer and approximation in one next state
	always_comb begin
		s_next = s_reg;
		// comparator settles within a clock of each trial code, so one
		// register keeps pace at divide by two; two would decide stale
		s_next.comp_sync = comp_keep;
		s_next.done = 1'b0;
		s_next.rdata = 8'h00;
		// read data stand for the single cycle after the strobe
		if (read_strobe) begin
			case (addr)
				adc_pkg::ADDR_RESULT_HIGH: s_next.rdata = s_reg.result_high;
				adc_pkg::ADDR_RESULT_LOW: s_next.rdata = s_reg.result_low;
				adc_pkg::ADDR_CTRL_ZERO: begin
					s_next.rdata = {2'h0, s_reg.channel,
						s_reg.go, s_reg.enable};
				end
				adc_pkg::ADDR_PIN_REF: begin
					s_next.rdata = {2'h0, s_reg.nref, s_reg.pref, s_reg.pcfg};
				end
				adc_pkg::ADDR_TIMING: begin
					s_next.rdata = {s_reg.justify, 1'b0,
						s_reg.acq, s_reg.clk_sel};
				end
				default: s_next.rdata = 8'h00;
			endcase
		end
		// sequencer leaves idle on go, then advances on bit period ticks only
		case (s_reg.st)
			adc_pkg::ST_IDLE: begin
				if (start) begin
					s_next.go = 1'b1;
					s_next.acq_count = 5'h00;
					if (s_reg.acq == adc_pkg::ACQ_RESET) begin
						s_next.st = adc_pkg::ST_CONV;
						s_next.conv_ticks = 4'h0;
						s_next.sar = adc_pkg::SAR_FIRST_TRIAL;
						s_next.trial = adc_pkg::SAR_FIRST_TRIAL;
					end else begin
						s_next.st = adc_pkg::ST_ACQ;
					end
				end
			end
			adc_pkg::ST_ACQ: begin
				if (tick) begin
					if (s_reg.acq_count ==
						adc_pkg::acq_periods(s_reg.acq) - 5'h01) begin
						s_next.st = adc_pkg::ST_CONV;
						s_next.conv_ticks = 4'h0;
						s_next.sar = adc_pkg::SAR_FIRST_TRIAL;
						s_next.trial = adc_pkg::SAR_FIRST_TRIAL;
					end else begin
						s_next.acq_count = s_reg.acq_count + 5'h01;
					end
				end
			end
			adc_pkg::ST_CONV: begin
				if (tick) begin
					s_next.conv_ticks = s_reg.conv_ticks + 4'h1;
					if (s_reg.conv_ticks == adc_pkg::CONV_PERIODS - 4'h1) begin
						// final period: store result and hand back to sampling
						s_next.st = adc_pkg::ST_IDLE;
						s_next.go = 1'b0;
						s_next.done = 1'b1;
						if (s_reg.justify) begin
							s_next.result_high = {6'h00, s_reg.sar[9:8]};
							s_next.result_low = s_reg.sar[7:0];
						end else begin
							s_next.result_high = s_reg.sar[9:2];
							s_next.result_low = {s_reg.sar[1:0], 6'h00};
						end
					end else begin
						// keep trial bit if held sample is at or above it
						if (!s_reg.comp_sync) begin
							s_next.sar = s_reg.sar & ~s_reg.trial;
						end
						s_next.trial = s_reg.trial >> 1;
						s_next.sar = s_next.sar | (s_reg.trial >> 1);
					end
				end
			end
			default: s_next.st = adc_pkg::ST_IDLE;
		endcase
		// software writes; results are read-only here
		if (write_strobe) begin
			case (addr)
				adc_pkg::ADDR_CTRL_ZERO: begin
					s_next.channel = wdata[adc_pkg::CHANNEL_LSB +: 4];
					s_next.enable = wdata[adc_pkg::ENABLE_BIT];
					if (!wdata[adc_pkg::ENABLE_BIT]) begin
						// switching off drops any conversion in flight
						s_next.st = adc_pkg::ST_IDLE;
						s_next.go = 1'b0;
						s_next.done = 1'b0;
					end
				end
				adc_pkg::ADDR_PIN_REF: begin
					s_next.nref = wdata[adc_pkg::NEG_REF_BIT];
					s_next.pref = wdata[adc_pkg::POS_REF_BIT];
					s_next.pcfg = wdata[adc_pkg::PCFG_LSB +: 4];
				end
				adc_pkg::ADDR_TIMING: begin
					s_next.justify = wdata[adc_pkg::JUSTIFY_BIT];
					s_next.acq = wdata[adc_pkg::ACQ_LSB +: 3];
					s_next.clk_sel = wdata[adc_pkg::CLK_SEL_LSB +: 3];
				end
				default: s_next.nref = s_next.nref;
			endcase
		end
		// reset clears control but keeps the result pair
		if (!resetn) begin
			s_next = '0;
			s_next.st = adc_pkg::ST_IDLE;
			s_next.channel = adc_pkg::CHANNEL_RESET;
			s_next.acq = adc_pkg::ACQ_RESET;
			s_next.clk_sel = adc_pkg::CLK_SEL_RESET;
			s_next.pcfg[2:0] = port_b_analog_default ?
				adc_pkg::PCFG_LOW_ANALOG : adc_pkg::PCFG_LOW_DIGITAL;
			s_next.result_high = s_reg.result_high;
			s_next.result_low = s_reg.result_low;
		end
	end

	always_ff @(posedge clock) begin
		s_reg <= s_next;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	sequence go_request;
		start;
	endsequence

	sequence final_period;
		s_reg.st == adc_pkg::ST_CONV && tick &&
			s_reg.conv_ticks == adc_pkg::CONV_PERIODS - 4'h1;
	endsequence

	go_busy_read_a: assert property (
		read_strobe && addr == adc_pkg::ADDR_CTRL_ZERO |=>
		rdata[adc_pkg::GO_BIT] == $past(s_reg.st != adc_pkg::ST_IDLE))
		else $error("go bit does not reflect busy state");

	zero_acq_start_a: assert property (
		go_request ##0 (s_reg.acq == adc_pkg::ACQ_RESET) |=>
		s_reg.st == adc_pkg::ST_CONV && !sample_enable)
		else $error("code zero did not convert at once");

	acq_inserted_a: assert property (
		go_request ##0 (s_reg.acq != adc_pkg::ACQ_RESET) |=>
		s_reg.st == adc_pkg::ST_ACQ && s_reg.go)
		else $error("acquisition interval skipped");

	conv_eleven_a: assert property (
		s_reg.done |-> s_reg.conv_ticks == 4'hb)
		else $error("conversion not eleven bit periods");

	done_clears_go_a: assert property (
		final_period |=> s_reg.done && !s_reg.go &&
		s_reg.st == adc_pkg::ST_IDLE ##1 !s_reg.done)
		else $error("completion did not clear go or flag once");

	right_justify_a: assert property (
		final_period ##0 s_reg.justify |=>
		s_reg.result_high == {6'h00, $past(s_reg.sar[9:8])} &&
		s_reg.result_low == $past(s_reg.sar[7:0]))
		else $error("right justified result misplaced");

	left_justify_a: assert property (
		final_period ##0 !s_reg.justify |=>
		{s_reg.result_high, s_reg.result_low} ==
		{$past(s_reg.sar), 6'h00})
		else $error("left justified result misplaced");

	resume_sample_a: assert property (
		s_reg.done |-> sample_enable)
		else $error("sampling not resumed after completion");

	disable_abort_a: assert property (
		ctrl_write && !wdata[adc_pkg::ENABLE_BIT] |=>
		s_reg.st == adc_pkg::ST_IDLE && !s_reg.go && !converter_enable)
		else $error("disable did not abort");

	reset_values_a: assert property (
		@(posedge clock) disable iff (1'b0)
		!resetn |=> !converter_enable && !s_reg.go &&
		s_reg.st == adc_pkg::ST_IDLE && s_reg.acq == adc_pkg::ACQ_RESET)
		else $error("reset did not restore control");

	strap_load_a: assert property (
		@(posedge clock) disable iff (1'b0)
		!resetn |=> s_reg.pcfg == (($past(port_b_analog_default)) ?
		4'h0 : 4'h7))
		else $error("pin code reset value wrong");

	pin_modes_a: assert property (
		(s_reg.pcfg <= adc_pkg::PCFG_ALL_ANALOG |-> &analog_mask) and
		(s_reg.pcfg == 4'hf |-> analog_mask == 13'h0000))
		else $error("pin analog mask wrong");

	no_channel_a: assert property (
		s_reg.channel > 4'hc |-> channel_onehot == 13'h0000)
		else $error("unimplemented code routed an input");

	sequence decide_step;
		s_reg.st == adc_pkg::ST_CONV && tick &&
			s_reg.conv_ticks != adc_pkg::CONV_PERIODS - 4'h1;
	endsequence

	ref_select_a: assert property (
		write_strobe && addr == adc_pkg::ADDR_PIN_REF |=>
		neg_ref_select == $past(wdata[adc_pkg::NEG_REF_BIT]) &&
		pos_ref_select == $past(wdata[adc_pkg::POS_REF_BIT]))
		else $error("reference select not taken from write");

	trial_onehot_a: assert property (
		decide_step |-> $onehot(s_reg.trial))
		else $error("approximation trial not a single bit");

	keep_decision_a: assert property (
		decide_step |=> (s_reg.sar & $past(s_reg.trial)) ==
		($past(s_reg.comp_sync) ? $past(s_reg.trial) : 10'h000))
		else $error("trial bit not decided by comparator");

	conv_span_a: assert property (
		s_reg.st == adc_pkg::ST_CONV |->
		s_reg.conv_ticks < adc_pkg::CONV_PERIODS)
		else $error("conversion ran past eleven bit periods");
endmodule

// >>> tb/analog_front_model.sv
`timescale 1ns/1ps
// sample-and-hold stage plus comparator facing the converter
module analog_front_model (
	input wire logic clock,
	input wire logic sample_enable,
	input wire logic [12:0] channel_onehot,
	input wire logic [9:0] level,
	input wire logic [9:0] dac_code,
	output logic comp_keep
);
	logic [9:0] held_reg;
	logic [9:0] float_reg = 10'h155;
	// each routed pin is an input; nothing drives level back
	// no channel routed: the input floats, so let it wander every cycle
	always_ff @(posedge clock) begin
		float_reg <= ~float_reg + 10'h001;
		if (sample_enable) begin
			held_reg <= (|channel_onehot) ? level : float_reg;
		end
	end
	// decision only against the held sample, never the live pin
	assign comp_keep = held_reg >= dac_code;
endmodule

// >>> tb/tb_adc_conversion_control.sv
`timescale 1ns/1ps
module tb_adc_conversion_control;
	logic clock = 1'h0;
	logic resetn = 1'h0;
	logic strap = 1'h1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic write_strobe = 1'h0;
	logic read_strobe = 1'h0;
	logic rc_clk = 1'h0;
	logic sleeping = 1'h0;
	logic [9:0] level = 10'h000;
	logic [7:0] rdata;
	logic comp_keep, neg_ref_select, pos_ref_select, sample_enable;
	logic converter_enable, conversion_done_flag;
	logic [12:0] channel_onehot, analog_mask;
	logic [9:0] dac_code;
	logic [7:0] d, hi, lo8;
	int bad_count = 0;
	int total_checks = 0;
	int wake_count = 0;
	int divs[8] = '{2, 8, 32, 7, 4, 16, 64, 7};
	int acqs[8] = '{0, 2, 4, 6, 8, 12, 16, 20};

	adc_conversion_control DUT (.clock(clock), .resetn(resetn),
		.port_b_analog_default(strap), .addr(addr), .wdata(wdata),
		.write_strobe(write_strobe), .read_strobe(read_strobe),
		.rdata(rdata), .internal_rc_clock(rc_clk), .sleeping(sleeping),
		.comp_keep(comp_keep), .channel_onehot(channel_onehot),
		.analog_mask(analog_mask), .neg_ref_select(neg_ref_select),
		.pos_ref_select(pos_ref_select), .sample_enable(sample_enable),
		.dac_code(dac_code), .converter_enable(converter_enable),
		.conversion_done_flag(conversion_done_flag));
	analog_front_model front (.clock(clock), .sample_enable(sample_enable),
		.channel_onehot(channel_onehot), .level(level),
		.dac_code(dac_code), .comp_keep(comp_keep));

	// system clock and a free-running rc oscillator of unrelated phase
	initial begin
		forever #50 clock = ~clock;
	end
	initial begin
		forever #370 rc_clk = ~rc_clk;
	end

	function automatic logic [12:0] mask_of(input logic [3:0] p);
		return (p < 4'h3) ? 13'h1fff : 13'h1fff >> (p - 4'h2);
	endfunction
	// result pair as {high, low}
	function automatic logic [15:0] pair_of(input logic [9:0] r,
		input logic j);
		return j ? {6'h00, r} : {r, 6'h00};
	endfunction

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clock);
		addr <= a;
		wdata <= v;
		write_strobe <= 1'h1;
		@(posedge clock);
		write_strobe <= 1'h0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge clock);
		addr <= a;
		read_strobe <= 1'h1;
		@(posedge clock);
		read_strobe <= 1'h0;
		@(negedge clock);
		v = rdata;
	endtask
	task automatic do_reset(input logic s);
		@(posedge clock);
		resetn <= 1'h0;
		strap <= s;
		repeat (12) @(posedge clock);
		resetn <= 1'h1;
	endtask
	// bounded wait for the completion pulse; counts negedges
	task automatic wait_done(input int lim, inout int n);
		while (conversion_done_flag !== 1'h1) begin
			@(negedge clock);
			n++;
			if (n > lim) begin
				bad_count++;
				print_verdict();
			end
		end
	endtask
	task automatic quiet(input int cycles);
		repeat (cycles) begin
			@(negedge clock);
			chk(conversion_done_flag, 1'h0);
		end
	endtask
	task automatic conv(input logic [2:0] c, input logic [2:0] q,
		input logic [3:0] ch, input logic [9:0] lv);
		int n;
		int lo;
		lo = (acqs[q] + 11) * divs[c];
		n = 3;
		level <= lv;
		wr(3'h4, {c[0], 1'h0, q, c});
		// enable first so the hold capacitor tracks before go
		wr(3'h2, {2'h0, ch, 2'h1});
		repeat (2) @(posedge clock);
		wr(3'h2, {2'h0, ch, 2'h3});
		rd(3'h2, d);
		chk(d, {2'h0, ch, 2'h3});
		wait_done(lo + lo / 8 + 20, n);
		chk(n >= lo, 1'h1);
		chk(sample_enable, 1'h1);
		@(negedge clock);
		chk(conversion_done_flag, 1'h0);
		rd(3'h2, d);
		chk(d, {2'h0, ch, 2'h1});
		rd(3'h0, hi);
		rd(3'h1, lo8);
		if (ch < 4'hd) begin
			chk({hi, lo8}, pair_of(lv, c[0]));
			chk(dac_code, lv);
		end
		// settle two bit periods before the next acquisition
		repeat (2 * divs[c] + 2) @(posedge clock);
	endtask

	initial begin
		d = 8'($urandom(32'h2192_50e1));
		do_reset(1'h1);
		rd(3'h2, d);
		chk(d, 8'h00);
		rd(3'h3, d);
		chk(d, 8'h00);
		rd(3'h4, d);
		chk(d, 8'h00);
		// register round trips and unmapped places
		for (int i = 0; i < 8; i++) begin
			d = 8'($urandom);
			wr(3'h3, d);
			rd(3'h3, hi);
			chk(hi, d & 8'h3f);
			chk({neg_ref_select, pos_ref_select}, d[5:4]);
			wr(3'h4, d);
			rd(3'h4, hi);
			chk(hi, d & 8'hbf);
			rd(3'h5 + 3'(i % 3), hi);
			chk(hi, 8'h00);
		end
		// every pin code and channel code
		for (int p = 0; p < 16; p++) begin
			wr(3'h3, 8'(p));
			@(negedge clock);
			chk(analog_mask, mask_of(4'(p)));
			wr(3'h2, 8'(p << 2));
			@(negedge clock);
			chk(channel_onehot, (p < 13) ? 13'h0001 << p : 13'h0000);
		end
		wr(3'h2, 8'h02);
		rd(3'h2, d);
		chk(d, 8'h00);
		chk(converter_enable, 1'h0);
		// one conversion per clock code and acquisition code
		for (int k = 0; k < 8; k++) begin
			conv(3'(k), 3'(k), 4'($urandom % 13),
				(k < 2) ? {10{k[0]}} : 10'($urandom));
		end
		conv(3'h0, 3'h0, 4'hf, 10'h2aa);
		conv(3'h0, 3'h2, 4'($urandom % 13), 10'($urandom));
		// system-clock conversion stalls in sleep, rc one does not
		sleeping <= 1'h1;
		conv(3'h3, 3'h1, 4'h5, 10'($urandom));
		wr(3'h4, 8'h00);
		wr(3'h2, 8'h03);
		quiet(60);
		@(posedge clock);
		sleeping <= 1'h0;
		wait_done(100, wake_count);
		// abort by clearing the enable bit mid-conversion
		wr(3'h4, 8'h06);
		wr(3'h2, 8'h07);
		repeat (6) @(posedge clock);
		wr(3'h2, 8'h04);
		quiet(40);
		rd(3'h2, d);
		chk(d, 8'h04);
		// reset mid-conversion keeps the result pair
		rd(3'h0, hi);
		rd(3'h1, lo8);
		wr(3'h0, 8'hff);
		wr(3'h1, 8'hff);
		wr(3'h2, 8'h03);
		repeat (5) @(posedge clock);
		do_reset(1'h0);
		rd(3'h0, d);
		chk(d, hi);
		rd(3'h1, d);
		chk(d, lo8);
		rd(3'h2, d);
		chk(d, 8'h00);
		rd(3'h3, d);
		chk(d, 8'h07);
		chk(analog_mask, 13'h00ff);
		do_reset(1'h1);
		rd(3'h3, d);
		chk(d, 8'h00);
		chk(analog_mask, 13'h1fff);
		print_verdict();
	end
endmodule
